//--- fhp_flash_model.sv
// Behavioural byte-wide flash device that answers the host sequencer.
// Assumes pins come straight from the host; busy times are shortened.
`timescale 1ns/10ps

module fhp_flash_model #(
    parameter int         PROG_NS   = 1000,
    parameter int         CHIP_NS   = 12000,
    parameter int         SECT_NS   = 2500,
    parameter real        PROT_NS   = 10000.0,
    parameter real        UNPROT_NS = 400.0,
    parameter logic [7:0] ID_CODE   = 8'h5a   // Arbitrary value
) (
    // Flash pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dout
);
    logic [7:0]  mem [0:131071];
    logic [7:0]  pdata = 8'h00;
    logic [16:0] padr = 17'h00000;
    logic        busy = 0, susp = 0, idm = 0, prot = 0, tog = 0, arm = 0, pend = 0;
    int          st = 0, kind = 0, left = 0;
    realtime     t0 = 0;

    // Power-up in read mode with an erased array
    initial begin
        dout = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
    end

    task automatic go(input int k, input int ns);
        kind = k;
        left = ns;
        busy = 1;
    endtask

    // Decodes data bytes only; unlock addresses are not checked
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        if (pend) begin
            pend = 0;
            padr = a;
            pdata = d;
            go(0, PROG_NS);
        end else if (st == 1) st = (d == 8'h55) ? 2 : 0;
        else if (st == 2) begin
            st = 0;
            if (arm && d == 8'h10) go(1, CHIP_NS);
            if (arm && d == 8'h30) padr = a;
            if (arm && d == 8'h30) go(2, SECT_NS);
            arm = (d == 8'h80);
            pend = (d == 8'ha0);
            if (d == 8'h90) idm = 1;
        end else if (d == 8'haa) st = 1;
        else if (d == 8'hb0) susp = 1;
        else if (d == 8'h30) susp = 0;
        else if (d == 8'hf0) idm = 0;
    endtask

    // Embedded timer; stands still while suspended
    always #10 begin
        if (busy && !susp) begin
            left = left - 10;
            if (left <= 0) begin
                if (kind == 0) mem[padr] = mem[padr] & pdata;
                for (int i = 0; i < 131072 && kind != 0; i++)
                    if (kind == 1 || i[16:13] == padr[16:13]) mem[i] = 8'hff;
                busy = 0;
            end
        end
    end

    always @(negedge we_n) t0 = $realtime;
    // Only a pulse with chip on and outputs off writes; long ones set protection, or clear it with addr[6] high
    always @(posedge we_n) begin
        if (!ce_n && oe_n) begin
            if ($realtime - t0 < 200.0) wr(addr, din);
            else if (addr[6] && $realtime - t0 >= UNPROT_NS) prot = 0;
            else if (!addr[6] && $realtime - t0 >= PROT_NS) prot = 1;
        end
    end

    always @(negedge oe_n) if (!ce_n && busy && !susp) tog = ~tog;

    // Released bus inverts its value on each change of a watched input, so two changes give back the old value
    always @(ce_n, oe_n, addr, busy, susp, idm, tog, prot) begin
        if (ce_n || oe_n) dout = ~dout;
        else if (busy && !susp) dout = {(kind == 0) ? ~pdata[7] : 1'b0, tog, 6'h00};
        else if (idm) dout = addr[1] ? {7'h00, prot} : ID_CODE;
        else dout = mem[addr];
    end
endmodule

//--- fhp_host.sv
// Host sequencer driving a byte-wide parallel flash through its pins.
// Assumes the flash is asynchronous; read data is synchronised on entry.
// Command sequences are built by the user from single write cycles.
//
// Summary of operation
// [RL1] Device programs and verifies byte internally
// [RL2] Host detects completion by polling and toggle
// [RL3] Bit 7 polls during program, then data
// [RL4] Bit 6 toggles while embedded operation busy
// [RL5] Chip erase verified internally by device
// [RL6] Bit 7 reads 0 erasing, 1 done
// [RL7] Sector erase selects sector by address bits
// [RL8] Program timeout no shorter than 210 us
// [RL9] Chip erase timeout no shorter than 24 s
// [RL10] Sector erase timeout no shorter than 8 s
// [RL11] Sector address load window lasts 100 us
// [RL12] Protect write pulse low at least 10 us
// [RL13] Unprotect write pulse low at least 12 ms
// [RL14] Reads allowed while erase is suspended
// [RL15] Write needs chip and write low, output high
// [RL16] Id read with address bit 1 shows protection
// [RL17] Device powers up in read mode
// [RL18] Program poll bit is complement of data
// [RL19] Toggle bit changes each read while busy
`timescale 1ns/10ps

module fhp_host
    import fhp_pkg::*;
#(
    parameter fhp_cnt_t PROG_TMO_CYC  = fhp_pkg::PROG_MAX_CYC,
    parameter fhp_cnt_t CHIP_TMO_CYC  = fhp_pkg::CHIP_MAX_CYC,
    parameter fhp_cnt_t SECT_TMO_CYC  = fhp_pkg::SECT_MAX_CYC,
    parameter fhp_cnt_t LOAD_CYC      = fhp_pkg::SECT_LOAD_CYC,
    parameter fhp_cnt_t UNPROT_CYC    = fhp_pkg::UNPROTECT_CYC
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // User command port
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire fhp_pkg::fhp_op_t         cmd_op,
    input  wire logic [fhp_pkg::AW-1:0]   cmd_addr,
    input  wire logic [fhp_pkg::DW-1:0]   cmd_data,
    // User response port
    output logic                          resp_valid,
    output logic                          resp_timeout,
    output logic [fhp_pkg::DW-1:0]        resp_data,
    // Flash pins
    output logic                          flash_ce_n,
    output logic                          flash_oe_n,
    output logic                          flash_we_n,
    output logic [fhp_pkg::AW-1:0]        flash_addr,
    output logic [fhp_pkg::DW-1:0]        flash_dq_out,
    output logic                          flash_dq_oe,
    input  wire logic [fhp_pkg::DW-1:0]   flash_dq_in
);
    import fhp_pkg::*;

    fhp_state_t        state_q;
    fhp_op_t           op_q;
    fhp_cnt_t          cnt_q;
    fhp_cnt_t          tmo_q;
    fhp_cnt_t          pulse_len;
    fhp_cnt_t          tmo_limit;
    logic [DW-1:0]     dq_s1_q;
    logic [DW-1:0]     dq_s2_q;
    logic [DW-1:0]     dq_s3_q;
    logic [DW-1:0]     rd_q;
    logic              first_q;
    logic              prev6_q;
    logic              poll_ok;
    logic              poll_done;
    logic              is_poll;

    // Data bus synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            dq_s3_q <= '0;
        end else begin
            dq_s1_q <= flash_dq_in;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
        end
    end

    // Write low time depends on the kind of write
    always_comb begin
        unique case (op_q)
            OP_PROTECT:   pulse_len = PROTECT_CYC;        // [RL12]
            OP_UNPROTECT: pulse_len = UNPROT_CYC;         // [RL13]
            default:      pulse_len = fhp_cnt_t'(WE_LOW_CYC);
        endcase
    end

    // Polling limit never shorter than the worst-case operation
    always_comb begin
        unique case (op_q)
            OP_POLL_CHIP: tmo_limit = CHIP_TMO_CYC;       // [RL9]
            OP_POLL_SECT: tmo_limit = SECT_TMO_CYC;       // [RL10]
            default:      tmo_limit = PROG_TMO_CYC;       // [RL8]
        endcase
    end

    // Completion test: polled bit shows final value and toggle has stopped
    always_comb begin
        is_poll   = (op_q == OP_POLL_PROG) || (op_q == OP_POLL_CHIP) || (op_q == OP_POLL_SECT);
        // Program polls against the written byte, erase waits for a one
        poll_ok   = (op_q == OP_POLL_PROG) ? (rd_q[POLL_BIT] == resp_data[POLL_BIT])  // [RL3] [RL18]
                                           : rd_q[POLL_BIT];                           // [RL6]
        poll_done = !first_q && (rd_q[TOGGLE_BIT] == prev6_q) && poll_ok;             // [RL2] [RL19]
    end

    assign cmd_ready = (state_q == ST_IDLE);

    // Elapsed cycles of the whole operation, frozen once idle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tmo_q <= '0;
        end else if (state_q == ST_IDLE) begin
            if (cmd_valid) begin
                tmo_q <= '0;
            end
        end else begin
            tmo_q <= tmo_q + fhp_cnt_t'(1);
        end
    end

    // Main sequencer; the user data register doubles as the poll reference
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q      <= ST_IDLE;
            op_q         <= OP_READ;
            cnt_q        <= '0;
            first_q      <= 1'b1;
            prev6_q      <= 1'b0;
            rd_q         <= '0;
            resp_valid   <= 1'b0;
            resp_timeout <= 1'b0;
            resp_data    <= '0;
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_addr   <= '0;
            flash_dq_out <= '0;
            flash_dq_oe  <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            cnt_q      <= cnt_q + fhp_cnt_t'(1);
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        op_q         <= cmd_op;
                        flash_addr   <= cmd_addr;       // [RL7] [RL16]
                        flash_dq_out <= cmd_data;
                        resp_data    <= cmd_data;
                        resp_timeout <= 1'b0;
                        cnt_q        <= '0;
                        first_q      <= 1'b1;
                        unique case (cmd_op)
                            OP_WRITE, OP_PROTECT, OP_UNPROTECT: begin
                                // Output enable stays high for any write
                                flash_ce_n  <= 1'b0;                      // [RL15]
                                flash_we_n  <= 1'b0;
                                flash_dq_oe <= (cmd_op == OP_WRITE);
                                state_q     <= ST_WR_LOW;
                            end
                            OP_LOAD_WAIT: begin
                                state_q <= ST_WAIT;
                            end
                            default: begin
                                // Plain reads also serve erase suspend
                                flash_ce_n <= 1'b0;                       // [RL14]
                                flash_oe_n <= 1'b0;
                                state_q    <= ST_RD_ACC;
                            end
                        endcase
                    end
                end
                ST_RD_ACC: begin
                    if (cnt_q == fhp_cnt_t'(ACC_CYC - 1)) begin
                        cnt_q   <= '0;
                        state_q <= ST_RD_SYNC;
                    end
                end
                ST_RD_SYNC: begin
                    // Take data once the last two stages agree
                    if (cnt_q >= fhp_cnt_t'(SYNC_CYC) && dq_s2_q == dq_s3_q) begin
                        rd_q       <= dq_s3_q;
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        cnt_q      <= '0;
                        state_q    <= ST_RD_REL;
                    end
                end
                ST_RD_REL: begin
                    // Bus float time before the next cycle may start
                    if (cnt_q >= fhp_cnt_t'(DF_CYC - 1)) begin
                        cnt_q <= '0;
                        if (!is_poll || poll_done) begin
                            resp_data  <= rd_q;
                            resp_valid <= 1'b1;
                            state_q    <= ST_IDLE;
                        end else if (tmo_q >= tmo_limit) begin
                            resp_data    <= rd_q;
                            resp_timeout <= 1'b1;
                            resp_valid   <= 1'b1;
                            state_q      <= ST_IDLE;
                        end else begin
                            // Device still busy; read again
                            prev6_q    <= rd_q[TOGGLE_BIT];           // [RL4]
                            first_q    <= 1'b0;
                            flash_ce_n <= 1'b0;
                            flash_oe_n <= 1'b0;
                            state_q    <= ST_RD_ACC;
                        end
                    end
                end
                ST_WR_LOW: begin
                    if (cnt_q == pulse_len - fhp_cnt_t'(1)) begin
                        flash_we_n <= 1'b1;
                        cnt_q      <= '0;
                        state_q    <= ST_WR_HIGH;
                    end
                end
                ST_WR_HIGH: begin
                    if (cnt_q == fhp_cnt_t'(WE_HIGH_CYC - 1)) begin
                        flash_ce_n  <= 1'b1;
                        flash_dq_oe <= 1'b0;
                        resp_valid  <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (cnt_q == LOAD_CYC - fhp_cnt_t'(1)) begin  // [RL11]
                        resp_valid <= 1'b1;
                        state_q    <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Helper: length of the current write-enable low time
    fhp_cnt_t we_low_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            we_low_q <= '0;
        end else begin
            we_low_q <= flash_we_n ? '0 : we_low_q + fhp_cnt_t'(1);
        end
    end

    a_write_gating: assert property (@(posedge clk) disable iff (!rstn)   // [RL15]
        !flash_we_n |-> (flash_oe_n && !flash_ce_n)) else $error("write enable low without write gating");
    a_drive_no_read: assert property (@(posedge clk) disable iff (!rstn)  // [RL15]
        flash_dq_oe |-> flash_oe_n) else $error("data driven while output enabled");
    a_protect_width: assert property (@(posedge clk) disable iff (!rstn)  // [RL12]
        ($rose(flash_we_n) && op_q == OP_PROTECT) |-> we_low_q >= PROTECT_CYC) else $error("protect pulse short");
    a_unprot_width: assert property (@(posedge clk) disable iff (!rstn)   // [RL13]
        ($rose(flash_we_n) && op_q == OP_UNPROTECT) |-> we_low_q >= UNPROT_CYC) else $error("unprotect pulse short");
    a_prog_timeout: assert property (@(posedge clk) disable iff (!rstn)   // [RL8]
        (resp_valid && resp_timeout && op_q == OP_POLL_PROG) |-> tmo_q >= PROG_TMO_CYC)
        else $error("program poll gave up early");
    a_chip_timeout: assert property (@(posedge clk) disable iff (!rstn)   // [RL9]
        (resp_valid && resp_timeout && op_q == OP_POLL_CHIP) |-> tmo_q >= CHIP_TMO_CYC)
        else $error("chip erase poll gave up early");
    a_sect_timeout: assert property (@(posedge clk) disable iff (!rstn)   // [RL10]
        (resp_valid && resp_timeout && op_q == OP_POLL_SECT) |-> tmo_q >= SECT_TMO_CYC)
        else $error("sector erase poll gave up early");
    a_load_window: assert property (@(posedge clk) disable iff (!rstn)    // [RL11]
        (resp_valid && op_q == OP_LOAD_WAIT) |-> tmo_q >= LOAD_CYC) else $error("load window too short");
    a_prog_done: assert property (@(posedge clk) disable iff (!rstn)      // [RL2]
        (resp_valid && !resp_timeout && op_q == OP_POLL_PROG) |-> ##1 (state_q == ST_IDLE && $stable(resp_data)))
        else $error("program completion response malformed");
    a_erase_done: assert property (@(posedge clk) disable iff (!rstn)     // [RL6]
        (resp_valid && !resp_timeout && (op_q == OP_POLL_CHIP || op_q == OP_POLL_SECT)) |-> resp_data[POLL_BIT])
        else $error("erase reported done with poll bit low");

endmodule

//--- fhp_host_tb_top.sv
// Self-checking bench for the flash host sequencer.
// Assumes the behavioural flash model sits on the pins; counts shortened.
`timescale 1ns/10ps

module fhp_host_tb_top;
    import fhp_pkg::*;
    logic        clk, rstn, cmd_valid, cmd_ready, resp_valid, resp_timeout;
    fhp_op_t     cmd_op;
    logic [16:0] cmd_addr, flash_addr;
    logic [7:0]  cmd_data, resp_data, flash_dq_out, flash_dq_in, mdout;
    logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    int          err_total = 0, num_checks = 0, we_cnt = 0, last_n = 0;

    fhp_host #(.PROG_TMO_CYC(400), .CHIP_TMO_CYC(2000), .SECT_TMO_CYC(1000), .LOAD_CYC(50),
               .UNPROT_CYC(100)) u_fhp_host (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .resp_valid(resp_valid), .resp_timeout(resp_timeout), .resp_data(resp_data),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in));
    fhp_flash_model u_fhp_flash_model (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .addr(flash_addr), .din(flash_dq_out), .dout(mdout));

    // Shared data wire: host wins while it drives
    assign flash_dq_in = flash_dq_oe ? flash_dq_out : mdout;

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end

    always @(negedge flash_we_n) we_cnt++;
    // Write strobe and data drive only with outputs off
    always @(posedge clk) begin
        if (rstn && !flash_we_n) check("we_pins", {flash_oe_n, flash_ce_n}, 2'b10);
        if (rstn && flash_dq_oe) check("dq_drive", flash_oe_n, 1);
    end

    task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One user operation, offered for a single cycle, bounded wait for its answer
    task automatic op(input fhp_op_t o, input logic [16:0] a, input logic [7:0] d);
        @(posedge clk);
        cmd_op <= o;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        last_n = 0;
        do begin
            @(posedge clk);
            #1;
            last_n++;
        end while (resp_valid !== 1'b1 && last_n < 20000);
        if (resp_valid !== 1'b1) begin
            check("resp_wait", resp_valid, 1'b1);
            results();
        end
    endtask

    task automatic cmd3(input logic [16:0] a, input logic [7:0] c);
        op(OP_WRITE, 17'h00555, 8'haa);
        op(OP_WRITE, 17'h002aa, 8'h55);
        op(OP_WRITE, a, c);
    endtask

    task automatic t_program(input logic [16:0] a, input logic [7:0] d);
        int c;
        logic [7:0] b;
        cmd3(17'h00555, 8'ha0);
        op(OP_WRITE, a, d);
        c = we_cnt;
        // Two reads well inside the busy time: complement, then a flipped toggle
        op(OP_READ, a, 8'h00);
        b = resp_data;
        check("prog_busy7", b[7], !d[7]);
        op(OP_READ, a, 8'h00);
        check("prog_tog", resp_data[6], !b[6]);
        op(OP_POLL_PROG, a, d);
        check("prog_tmo", resp_timeout, 0);
        check("prog_poll", resp_data, d);
        check("no_extra_we", we_cnt, c);
        op(OP_READ, a, 8'h00);
        check("prog_read", resp_data, d);
    endtask

    task automatic t_chip();
        cmd3(17'h00555, 8'h80);
        cmd3(17'h00555, 8'h10);
        // Bit 7 matches a zero reference, so only the running toggle keeps it busy
        op(OP_POLL_PROG, 17'h00000, 8'h00);
        check("tog_busy_tmo", resp_timeout, 1);
        op(OP_POLL_CHIP, 17'h00000, 8'h00);
        check("chip_tmo1", resp_timeout, 1);
        check("chip_busy7", resp_data[7], 0);
        op(OP_POLL_CHIP, 17'h00000, 8'h00);
        check("chip_tmo2", resp_timeout, 0);
        check("chip_done", resp_data, 8'hff);
        op(OP_READ, 17'h00123, 8'h00);
        check("chip_read", resp_data, 8'hff);
    endtask

    task automatic t_sector();
        t_program(17'h04000, 8'h11);
        t_program(17'h00010, 8'h22);
        cmd3(17'h00555, 8'h80);
        cmd3(17'h04000, 8'h30);
        op(OP_LOAD_WAIT, 17'h04000, 8'h00);
        check("load_len", last_n >= 50, 1);
        op(OP_WRITE, 17'h00000, 8'hb0);
        op(OP_READ, 17'h00010, 8'h00);
        check("susp_read", resp_data, 8'h22);
        op(OP_WRITE, 17'h00000, 8'h30);
        op(OP_POLL_SECT, 17'h04000, 8'h00);
        check("sect_tmo", resp_timeout, 0);
        op(OP_READ, 17'h04000, 8'h00);
        check("sect_erased", resp_data, 8'hff);
        op(OP_READ, 17'h00010, 8'h00);
        check("sect_kept", resp_data, 8'h22);
    endtask

    task automatic t_protect(input fhp_op_t o, input logic [16:0] a, input logic [7:0] e);
        op(o, a, 8'h00);
        cmd3(17'h00555, 8'h90);
        op(OP_READ, 17'h00002, 8'h00);
        check("prot_id", resp_data, e);
        op(OP_WRITE, 17'h00000, 8'hf0);
    endtask

    initial begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_READ;
        cmd_addr = 17'h00000;
        cmd_data = 8'h00;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check("idle_pins", {flash_ce_n, flash_we_n, flash_dq_oe, cmd_ready}, 4'hd);
        t_program(17'h00123, 8'h3c);
        t_chip();
        t_sector();
        t_protect(OP_PROTECT, 17'h00000, 8'h01);
        t_protect(OP_UNPROTECT, 17'h00040, 8'h00);
        results();
    end
endmodule

//--- fhp_pkg.sv
// Constants and types for the parallel flash host sequencer.
// Assumes a 250 MHz system clock; all pin timings become cycle counts here.
package fhp_pkg;

    // System clock rate
    localparam int unsigned CLK_MHZ        = 250;

    // Bus cycle times in ns, slowest speed grade so both grades work
    localparam int unsigned T_ACC_NS       = 120;
    localparam int unsigned T_WE_LOW_NS    = 50;
    localparam int unsigned T_WE_HIGH_NS   = 20;
    localparam int unsigned T_DF_NS        = 40;

    // Least times round up to whole cycles
    localparam int unsigned ACC_CYC        = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WE_LOW_CYC     = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WE_HIGH_CYC    = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DF_CYC         = (T_DF_NS * CLK_MHZ + 999) / 1000;

    // Input synchroniser depth before read data may be trusted
    localparam int unsigned SYNC_CYC       = 3;

    // Counter width; chip erase needs over 32 bits of cycles
    localparam int unsigned TW             = 40;
    typedef logic [TW-1:0] fhp_cnt_t;

    // Long times in their own units
    localparam int unsigned PROTECT_PULSE_US   = 10;
    localparam int unsigned UNPROTECT_PULSE_MS = 12;
    localparam int unsigned SECT_LOAD_US       = 100;
    localparam int unsigned PROG_MAX_US        = 210;
    localparam int unsigned CHIP_ERASE_MAX_S   = 24;
    localparam int unsigned SECT_ERASE_MAX_S   = 8;

    // Derived cycle counts
    localparam fhp_cnt_t PROTECT_CYC   = fhp_cnt_t'(PROTECT_PULSE_US * CLK_MHZ);
    localparam fhp_cnt_t UNPROTECT_CYC = fhp_cnt_t'(UNPROTECT_PULSE_MS) * fhp_cnt_t'(1000 * CLK_MHZ);
    localparam fhp_cnt_t SECT_LOAD_CYC = fhp_cnt_t'(SECT_LOAD_US * CLK_MHZ);
    localparam fhp_cnt_t PROG_MAX_CYC  = fhp_cnt_t'(PROG_MAX_US * CLK_MHZ);
    localparam fhp_cnt_t CHIP_MAX_CYC  = fhp_cnt_t'(CHIP_ERASE_MAX_S) * fhp_cnt_t'(CLK_MHZ) * fhp_cnt_t'(1000000);
    localparam fhp_cnt_t SECT_MAX_CYC  = fhp_cnt_t'(SECT_ERASE_MAX_S) * fhp_cnt_t'(CLK_MHZ) * fhp_cnt_t'(1000000);

    // Bus widths
    localparam int unsigned AW = 17;
    localparam int unsigned DW = 8;

    // Status bit positions on the data bus
    localparam int unsigned POLL_BIT   = 7;
    localparam int unsigned TOGGLE_BIT = 6;

    // User operations
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_POLL_PROG,
        OP_POLL_CHIP,
        OP_POLL_SECT,
        OP_LOAD_WAIT,
        OP_PROTECT,
        OP_UNPROTECT
    } fhp_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ACC,
        ST_RD_SYNC,
        ST_RD_REL,
        ST_WR_LOW,
        ST_WR_HIGH,
        ST_WAIT
    } fhp_state_t;

endpackage
